// File: hw/tlbm_core.sv
/*
 * Translation-buffer management block: probe, read at pointer, write at
 * pointer and write at replacement pointer, moving entries between the
 * entry array and the staging registers. Staging and pointer registers
 * are reached over an Avalon-MM slave with waitrequest.
 * Assumes the instruction pipeline on the same clock presents one
 * operation word per op_valid cycle, together with its access right.
 */
`timescale 1ns/1ns
module tlbm_core #(
    parameter int unsigned ENTRIES    = 16,
    parameter bit          MASK_CLEAR = 1'b1
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          op_valid,
    input  wire logic [tlbm_pkg::DATA_W-1:0]   op_word,
    input  wire logic                          op_cp_usable,
    output logic                               op_done,
    output logic                               op_unusable,
    input  wire logic [tlbm_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [tlbm_pkg::DATA_W-1:0]   avs_writedata,
    input  wire logic [3:0]                    avs_byteenable,
    output logic [tlbm_pkg::DATA_W-1:0]        avs_readdata,
    output logic                               avs_waitrequest
);
    import tlbm_pkg::*;

    localparam int unsigned IW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
    localparam logic [IW-1:0] LAST_IDX = IW'(ENTRIES - 1);

    typedef struct packed {
        tlbm_entry_t [ENTRIES-1:0] ent;
        tlbm_hi_t                  hi;
        tlbm_lo_t                  lo0;
        tlbm_lo_t                  lo1;
        logic [MASK_W-1:0]         size;
        logic [IW-1:0]             ptr_idx;
        logic                      ptr_miss;
        logic [IW-1:0]             repl;
        tlbm_bus_t                 bus;
        logic                      waitreq;
        logic [DATA_W-1:0]         rdata;
        logic                      done;
        logic                      unusable;
    } tlbm_state_t;

    tlbm_state_t s;
    tlbm_state_t next_s;

    // Fixed fields select one of the four operations, else none
    function automatic tlbm_op_t decode_op(input logic [DATA_W-1:0] w);
        tlbm_op_t op;
        op = TLBM_OP_NONE;
        if (w[MAJOR_HI:MAJOR_LO] == SYSTEM_COPROC_OPCODE && w[SUB_OP_BIT]
            && w[ZERO_HI:ZERO_LO] == '0) begin
            unique case (w[FUNC_HI:FUNC_LO])
                FUNC_PROBE:      op = TLBM_OP_PROBE;
                FUNC_READ:       op = TLBM_OP_READ;
                FUNC_WRITE_PTR:  op = TLBM_OP_WRITE_PTR;
                FUNC_WRITE_REPL: op = TLBM_OP_WRITE_REPL;
                default:         op = TLBM_OP_NONE;
            endcase
        end
        return op;
    endfunction

    // Size bits line up LSB to LSB with page-pair and frame numbers
    function automatic logic [VIRT_PAGE_PAIR_NUM_W-1:0] clr_virt_page_pair_num(
        input logic [VIRT_PAGE_PAIR_NUM_W-1:0] v, input logic [MASK_W-1:0] m);
        return MASK_CLEAR ? (v & ~VIRT_PAGE_PAIR_NUM_W'(m)) : v;
    endfunction

    function automatic logic [PFN_W-1:0] clr_pfn(
        input logic [PFN_W-1:0] p, input logic [MASK_W-1:0] m);
        return MASK_CLEAR ? (p & ~PFN_W'(m)) : p;
    endfunction

    function automatic logic [DATA_W-1:0] be_merge(
        input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
        input logic [3:0] be);
        logic [DATA_W-1:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [DATA_W-1:0] pack_hi(input tlbm_hi_t h);
        return {h.space, h.virt_page_pair_num, {HI_GAP_W{1'b0}}, h.tag};
    endfunction

    function automatic logic [DATA_W-1:0] pack_lo(input tlbm_lo_t l);
        return {{LO_FILL_W{1'b0}}, l};
    endfunction

    function automatic tlbm_hi_t unpack_hi(input logic [DATA_W-1:0] w);
        tlbm_hi_t h;
        h.space = w[HI_SPACE_LO +: SPACE_W];
        h.virt_page_pair_num  = w[HI_VIRT_PAGE_PAIR_NUM_LO +: VIRT_PAGE_PAIR_NUM_W];
        h.tag   = w[HI_TAG_LO +: TAG_W];
        return h;
    endfunction

    function automatic tlbm_lo_t unpack_lo(input logic [DATA_W-1:0] w);
        return tlbm_lo_t'(w[LO_BODY_LO +: $bits(tlbm_lo_t)]);
    endfunction

    function automatic logic [DATA_W-1:0] pack_ptr(
        input logic miss, input logic [IW-1:0] idx);
        logic [DATA_W-1:0] w;
        w = ZERO_WORD;
        w[PTR_MISS_BIT] = miss;
        w[IW-1:0] = idx;
        return w;
    endfunction

    function automatic logic entry_match(
        input tlbm_entry_t e, input tlbm_hi_t h);
        return ((e.virt_page_pair_num & ~VIRT_PAGE_PAIR_NUM_W'(e.mask)) == (h.virt_page_pair_num & ~VIRT_PAGE_PAIR_NUM_W'(e.mask)))
            && (e.all_spaces || e.tag == h.tag);
    endfunction

    // Same transfer for both write operations
    function automatic tlbm_entry_t build_entry(
        input tlbm_hi_t h, input tlbm_lo_t l0, input tlbm_lo_t l1,
        input logic [MASK_W-1:0] m);
        tlbm_entry_t e;
        e.mask           = m;
        e.space          = h.space;
        e.tag            = h.tag;
        e.virt_page_pair_num           = clr_virt_page_pair_num(h.virt_page_pair_num, m);
        e.all_spaces     = l0.all_spaces & l1.all_spaces;
        e.even_frame_num = clr_pfn(l0.phys_frame_num, m);
        e.odd_frame_num  = clr_pfn(l1.phys_frame_num, m);
        e.even_attr      = l0.attr;
        e.even_write_ok  = l0.write_ok;
        e.even_entry_ok  = l0.entry_ok;
        e.odd_attr       = l1.attr;
        e.odd_write_ok   = l1.write_ok;
        e.odd_entry_ok   = l1.entry_ok;
        return e;
    endfunction

    always_comb begin
        tlbm_op_t          op;
        tlbm_entry_t       rd;
        logic              found;
        logic [IW-1:0]     hit_idx;
        logic [DATA_W-1:0] rword;
        logic [DATA_W-1:0] wword;
        op      = decode_op(op_word);
        rd      = s.ent[s.ptr_idx];
        found   = 1'b0;
        hit_idx = '0;
        rword   = ZERO_WORD;
        wword   = ZERO_WORD;
        next_s  = s;
        next_s.done     = 1'b0;
        next_s.unusable = 1'b0;

        // Free-running down counter picks a pseudo-random victim
        next_s.repl = (s.repl == '0) ? LAST_IDX : s.repl - 1'b1;

        // Bus: request seen in IDLE, answered with waitrequest low in ACK
        unique case (s.bus)
            TLBM_BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    unique case (avs_address)
                        OFF_ENTRY_PTR:   rword = pack_ptr(s.ptr_miss,
                                                          s.ptr_idx);
                        OFF_REPLACE_PTR: rword = DATA_W'(s.repl);
                        OFF_SIZE_SELECT: rword = DATA_W'(s.size) << SIZE_LO;
                        OFF_TRANS_HIGH:  rword = pack_hi(s.hi);
                        OFF_EVEN_LOW:    rword = pack_lo(s.lo0);
                        OFF_ODD_LOW:     rword = pack_lo(s.lo1);
                        default:         rword = ZERO_WORD;
                    endcase
                    next_s.rdata   = avs_read ? rword : ZERO_WORD;
                    next_s.bus     = TLBM_BUS_ACK;
                    next_s.waitreq = 1'b0;
                end
            end
            TLBM_BUS_ACK: begin
                next_s.bus     = TLBM_BUS_IDLE;
                next_s.waitreq = 1'b1;
                if (avs_write) begin
                    unique case (avs_address)
                        OFF_ENTRY_PTR: begin
                            wword = be_merge(pack_ptr(s.ptr_miss, s.ptr_idx),
                                             avs_writedata, avs_byteenable);
                            next_s.ptr_miss = wword[PTR_MISS_BIT];
                            next_s.ptr_idx  = wword[IW-1:0];
                        end
                        OFF_SIZE_SELECT: begin
                            wword = be_merge(DATA_W'(s.size) << SIZE_LO,
                                             avs_writedata, avs_byteenable);
                            next_s.size = wword[SIZE_LO +: MASK_W];
                        end
                        OFF_TRANS_HIGH: begin
                            wword = be_merge(pack_hi(s.hi), avs_writedata,
                                             avs_byteenable);
                            next_s.hi = unpack_hi(wword);
                        end
                        OFF_EVEN_LOW: begin
                            wword = be_merge(pack_lo(s.lo0), avs_writedata,
                                             avs_byteenable);
                            next_s.lo0 = unpack_lo(wword);
                        end
                        OFF_ODD_LOW: begin
                            wword = be_merge(pack_lo(s.lo1), avs_writedata,
                                             avs_byteenable);
                            next_s.lo1 = unpack_lo(wword);
                        end
                        default: begin
                            wword = ZERO_WORD;
                        end
                    endcase
                end
            end
        endcase

        // Lowest-numbered matching entry wins
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (entry_match(s.ent[i], s.hi)) begin
                found   = 1'b1;
                hit_idx = IW'(i);
            end
        end

        // Operations come last so they win over a same-cycle bus write
        if (op_valid && op != TLBM_OP_NONE) begin
            if (!op_cp_usable) begin
                next_s.unusable = 1'b1;
            end else begin
                next_s.done = 1'b1;
                unique case (op)
                    TLBM_OP_PROBE: begin
                        next_s.ptr_miss = !found;
                        if (found) begin
                            next_s.ptr_idx = hit_idx;
                        end
                    end
                    TLBM_OP_READ: begin
                        // Pointer beyond the array is the issuer's fault
                        next_s.size     = rd.mask;
                        next_s.hi.space = rd.space;
                        next_s.hi.tag   = rd.tag;
                        next_s.hi.virt_page_pair_num  = clr_virt_page_pair_num(rd.virt_page_pair_num,
                                                   rd.mask);
                        next_s.lo0.phys_frame_num  = clr_pfn(rd.even_frame_num,
                                                  rd.mask);
                        next_s.lo1.phys_frame_num  = clr_pfn(rd.odd_frame_num,
                                                  rd.mask);
                        next_s.lo0.attr       = rd.even_attr;
                        next_s.lo0.write_ok   = rd.even_write_ok;
                        next_s.lo0.entry_ok   = rd.even_entry_ok;
                        next_s.lo1.attr       = rd.odd_attr;
                        next_s.lo1.write_ok   = rd.odd_write_ok;
                        next_s.lo1.entry_ok   = rd.odd_entry_ok;
                        next_s.lo0.all_spaces = rd.all_spaces;
                        next_s.lo1.all_spaces = rd.all_spaces;
                    end
                    TLBM_OP_WRITE_PTR: begin
                        next_s.ent[s.ptr_idx] = build_entry(s.hi, s.lo0,
                                                  s.lo1, s.size);
                    end
                    TLBM_OP_WRITE_REPL: begin
                        next_s.ent[s.repl] = build_entry(s.hi, s.lo0,
                                                  s.lo1, s.size);
                    end
                    default: begin
                        next_s.done = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s         <= '0;
            s.repl    <= LAST_IDX;
            s.bus     <= TLBM_BUS_IDLE;
            s.waitreq <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign op_done         = s.done;
    assign op_unusable     = s.unusable;
    assign avs_readdata    = s.rdata;
    assign avs_waitrequest = s.waitreq;

endmodule // tlbm_core

// File: hw/tlbm_pkg.sv
/*
 * Constants, field layouts and types for the translation-buffer
 * management block: operation encodings, staging register layouts,
 * register offsets on the Avalon-MM slave, and the entry format.
 * Assumes a 32-bit instruction word and 32-bit register data.
 */
package tlbm_pkg;

    localparam int unsigned DATA_W     = 32;
    localparam int unsigned ADDR_W     = 5;

    // Instruction word fields
    localparam int unsigned MAJOR_HI   = 31;
    localparam int unsigned MAJOR_LO   = 26;
    localparam int unsigned SUB_OP_BIT = 25;
    localparam int unsigned ZERO_HI    = 24;
    localparam int unsigned ZERO_LO    = 6;
    localparam int unsigned FUNC_HI    = 5;
    localparam int unsigned FUNC_LO    = 0;
    localparam logic [5:0]  SYSTEM_COPROC_OPCODE = 6'h10;
    localparam logic [5:0]  FUNC_PROBE      = 6'h08;
    localparam logic [5:0]  FUNC_READ       = 6'h01;
    localparam logic [5:0]  FUNC_WRITE_PTR  = 6'h02;
    localparam logic [5:0]  FUNC_WRITE_REPL = 6'h06;

    // Field widths
    localparam int unsigned SPACE_W    = 2;
    localparam int unsigned VIRT_PAGE_PAIR_NUM_W     = 17;
    localparam int unsigned HI_GAP_W   = 5;
    localparam int unsigned TAG_W      = 8;
    localparam int unsigned MASK_W     = 16;
    localparam int unsigned PFN_W      = 24;
    localparam int unsigned ATTR_W     = 3;
    localparam int unsigned LO_FILL_W  = 2;

    // Field positions in the staging words
    localparam int unsigned HI_SPACE_LO = 30;
    localparam int unsigned HI_VIRT_PAGE_PAIR_NUM_LO  = 13;
    localparam int unsigned HI_TAG_LO   = 0;
    localparam int unsigned SIZE_LO     = 13;
    localparam int unsigned LO_BODY_LO  = 0;
    localparam int unsigned PTR_MISS_BIT = 31;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_ENTRY_PTR   = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_REPLACE_PTR = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_SIZE_SELECT = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_TRANS_HIGH  = 5'h0c;
    localparam logic [ADDR_W-1:0] OFF_EVEN_LOW    = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_ODD_LOW     = 5'h14;

    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        TLBM_OP_NONE,
        TLBM_OP_PROBE,
        TLBM_OP_READ,
        TLBM_OP_WRITE_PTR,
        TLBM_OP_WRITE_REPL
    } tlbm_op_t;

    typedef enum logic {
        TLBM_BUS_IDLE,
        TLBM_BUS_ACK
    } tlbm_bus_t;

    typedef struct packed {
        logic [SPACE_W-1:0] space;
        logic [VIRT_PAGE_PAIR_NUM_W-1:0]  virt_page_pair_num;
        logic [TAG_W-1:0]   tag;
    } tlbm_hi_t;

    // Bit order matches the page-low word below its zero fill
    typedef struct packed {
        logic [PFN_W-1:0]  phys_frame_num;
        logic [ATTR_W-1:0] attr;
        logic              write_ok;
        logic              entry_ok;
        logic              all_spaces;
    } tlbm_lo_t;

    typedef struct packed {
        logic [MASK_W-1:0]  mask;
        logic [SPACE_W-1:0] space;
        logic [VIRT_PAGE_PAIR_NUM_W-1:0]  virt_page_pair_num;
        logic [TAG_W-1:0]   tag;
        logic               all_spaces;
        logic [PFN_W-1:0]   even_frame_num;
        logic [ATTR_W-1:0]  even_attr;
        logic               even_write_ok;
        logic               even_entry_ok;
        logic [PFN_W-1:0]   odd_frame_num;
        logic [ATTR_W-1:0]  odd_attr;
        logic               odd_write_ok;
        logic               odd_entry_ok;
    } tlbm_entry_t;

endpackage

// File: tb/tlbm_core_bench.sv
/* Self-checking bench for tlbm_core: bus master, reference model of
   entries and staging registers, directed and random tests.
   Assumes MASK_CLEAR set and sixteen entries. */
`timescale 1ns/1ns
module tlbm_core_bench;
    import tlbm_pkg::*;
    localparam int N = 16;
    // Readable bits per slot; slot 1 is the read-only replacement pointer
    localparam logic [31:0] RMASK [6] = '{32'h8000_000f, 32'h0000_0000,
        32'h1fff_e000, 32'hffff_e0ff, 32'h3fff_ffff, 32'h3fff_ffff};
    localparam logic [5:0] FUNCS [4] = '{FUNC_PROBE, FUNC_READ,
        FUNC_WRITE_PTR, FUNC_WRITE_REPL};
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              op_valid, op_cp_usable, op_done, op_unusable;
    logic [DATA_W-1:0] op_word, avs_readdata;
    logic [DATA_W-1:0] avs_writedata = 32'h0000_0000;
    logic [ADDR_W-1:0] avs_address = 5'h00;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [3:0]        avs_byteenable = 4'hf;
    logic              avs_waitrequest;
    logic [DATA_W-1:0] m_reg [6];
    logic [DATA_W-1:0] m_hi [N], m_lo0 [N], m_lo1 [N], m_sz [N];
    int                bad_count = 0;
    int                samples_checked = 0;
    int                cycles = 0;

    always #2 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    tlbm_pipe pipe (.clk(clk), .op_valid(op_valid), .op_word(op_word),
        .op_cp_usable(op_cp_usable), .op_done(op_done),
        .op_unusable(op_unusable));
    tlbm_core #(.ENTRIES(N), .MASK_CLEAR(1'b1)) uut (.clk(clk), .rst(rst),
        .op_valid(op_valid), .op_word(op_word), .op_cp_usable(op_cp_usable),
        .op_done(op_done), .op_unusable(op_unusable),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic bus(input logic wr, input int a, input logic [31:0] wd,
                       input logic [3:0] be, output logic [31:0] rd);
        @(posedge clk);
        avs_address <= 5'(a);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic reg_wr(input int k, input logic [31:0] v,
                          input logic [3:0] be = 4'hf);
        logic [31:0] bm, rd;
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        if (k != 1) m_reg[k] = ((m_reg[k] & ~bm) | (v & bm)) & RMASK[k];
        bus(1'b1, k * 4, v, be, rd);
    endtask
    task automatic check_stage;
        logic [31:0] rd;
        for (int k = 0; k < 6; k++) begin
            if (k == 1) continue;
            bus(1'b0, k * 4, 32'h0000_0000, 4'hf, rd);
            check(rd, m_reg[k]);
        end
    endtask
    task automatic m_write(input int i);
        logic g;
        g = m_reg[4][0] & m_reg[5][0];
        m_sz[i] = m_reg[2];
        m_hi[i] = m_reg[3] & ~m_reg[2];
        m_lo0[i] = m_reg[4] & ~(m_reg[2] >> 7) & ~32'h1 | 32'(g);
        m_lo1[i] = (m_reg[5] & ~(m_reg[2] >> 7) & ~32'h1) | 32'(g);
    endtask
    task automatic m_read(input int i);
        m_reg[2] = m_sz[i];
        m_reg[3] = m_hi[i];
        m_reg[4] = m_lo0[i];
        m_reg[5] = m_lo1[i];
    endtask
    task automatic m_probe;
        int hit;
        hit = -1;
        for (int i = N - 1; i >= 0; i--)
            if ((((m_hi[i] ^ m_reg[3]) & 32'h3fff_e000 & ~m_sz[i]) == 0) &&
                (m_lo0[i][0] || m_hi[i][7:0] == m_reg[3][7:0]))
                hit = i;
        if (hit < 0) m_reg[0][31] = 1'b1;
        else m_reg[0] = 32'(hit);
    endtask
    task automatic do_op(input logic [5:0] f, input logic u);
        logic d, x, ok;
        ok = f inside {FUNC_PROBE, FUNC_READ, FUNC_WRITE_PTR, FUNC_WRITE_REPL};
        pipe.issue({SYSTEM_COPROC_OPCODE, 1'b1, 19'h0_0000, f}, u, d, x);
        check({31'h0, d}, {31'h0, ok & u});
        check({31'h0, x}, {31'h0, ok & ~u});
        if (u && f == FUNC_PROBE) m_probe();
        if (u && f == FUNC_READ) m_read(m_reg[0][3:0]);
        if (u && f == FUNC_WRITE_PTR) m_write(m_reg[0][3:0]);
    endtask

    initial begin
        logic [31:0] rd;
        logic        dn, xx;
        void'($urandom(32'h1fa15355));
        for (int i = 0; i < N; i++)
            {m_hi[i], m_lo0[i], m_lo1[i], m_sz[i]} = '0;
        for (int k = 0; k < 6; k++) m_reg[k] = 32'h0000_0000;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        check_stage();
        bus(1'b1, 5'h18, $urandom, 4'hf, rd);
        bus(1'b0, 5'h18, 32'h0000_0000, 4'hf, rd);
        check(rd, 32'h0000_0000);
        bus(1'b0, OFF_REPLACE_PTR, 32'h0000_0000, 4'hf, rd);
        check({31'h0, rd < N}, 32'h0000_0001);
        $display("reset and unmapped test done");
        for (int k = 0; k < 6; k++) reg_wr(k, $urandom);
        reg_wr(3, $urandom, 4'b0101);
        reg_wr(2, $urandom, 4'b1010);
        check_stage();
        $display("staging register test done");
        // Bit 29 kept clear so later high words with it set never match
        for (int i = 0; i < N; i++) begin
            reg_wr(0, i);
            reg_wr(2, $urandom);
            reg_wr(3, $urandom & 32'hdfff_ffff);
            reg_wr(4, $urandom);
            reg_wr(5, $urandom);
            do_op(FUNC_WRITE_PTR, 1'b1);
        end
        for (int i = 0; i < N; i++) begin
            reg_wr(0, i);
            do_op(FUNC_READ, 1'b1);
            check_stage();
        end
        $display("write and read entry test done");
        for (int j = 0; j < 4; j++) begin
            reg_wr(3, m_hi[$urandom % N] ^ 32'(j));
            do_op(FUNC_PROBE, 1'b1);
            check_stage();
        end
        reg_wr(3, $urandom | 32'h2000_0000);
        do_op(FUNC_PROBE, 1'b1);
        check_stage();
        $display("probe test done");
        reg_wr(0, 2);
        for (int j = 0; j < 4; j++) do_op(FUNCS[j], 1'b0);
        do_op(6'h03, 1'b1);
        do_op(6'h09, 1'b1);
        do_op(FUNC_READ, 1'b1);
        check_stage();
        $display("barred and foreign word test done");
        reg_wr(2, 0);
        reg_wr(3, $urandom | 32'h2000_0000);
        reg_wr(4, $urandom | 32'h1);
        reg_wr(5, $urandom | 32'h1);
        do_op(FUNC_WRITE_REPL, 1'b1);
        pipe.issue({SYSTEM_COPROC_OPCODE, 1'b1, 19'h0_0000, FUNC_PROBE},
                   1'b1, dn, xx);
        bus(1'b0, OFF_ENTRY_PTR, 32'h0000_0000, 4'hf, rd);
        check({rd[31:4], 4'h0}, 32'h0000_0000);
        m_write(rd[3:0]);
        m_reg[0] = {28'h000_0000, rd[3:0]};
        do_op(FUNC_READ, 1'b1);
        check_stage();
        $display("replacement write test done");
        results();
    end
endmodule // tlbm_core_bench

// File: tb/tlbm_core_props.sv
/* Port-level assertions for tlbm_core, bound to every instance.
   Assumes a bus master that drops its request after each answer. */
`timescale 1ns/1ns
module tlbm_core_props
    import tlbm_pkg::*;
#(
    parameter int unsigned ENTRIES = 16
) (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic                        op_valid,
    input wire logic [tlbm_pkg::DATA_W-1:0] op_word,
    input wire logic                        op_cp_usable,
    input wire logic                        op_done,
    input wire logic                        op_unusable,
    input wire logic [tlbm_pkg::ADDR_W-1:0] avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [tlbm_pkg::DATA_W-1:0] avs_readdata,
    input wire logic                        avs_waitrequest
);
    localparam int unsigned IW = $clog2(ENTRIES);
    logic is_op;
    assign is_op = op_valid && op_word[31:25] == {SYSTEM_COPROC_OPCODE, 1'b1}
        && op_word[24:6] == 19'h0_0000 && op_word[5:0] inside
        {FUNC_PROBE, FUNC_READ, FUNC_WRITE_PTR, FUNC_WRITE_REPL};
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_op_ok; is_op && op_cp_usable; endsequence
    sequence s_op_barred; is_op && !op_cp_usable; endsequence
    sequence s_rd_taken; avs_read && avs_waitrequest; endsequence
    sequence s_answer; !avs_waitrequest ##1 avs_waitrequest; endsequence
    chk_op_done:
        assert property (s_op_ok |=> op_done && !op_unusable)
        else $error("operation not acknowledged");
    chk_op_barred:
        assert property (s_op_barred |=> op_unusable && !op_done)
        else $error("barred operation not trapped");
    chk_op_quiet:
        assert property (!is_op |=> !op_done && !op_unusable)
        else $error("pulse without a management word");
    chk_no_both:
        assert property (!(op_done && op_unusable))
        else $error("done and trap together");
    chk_bus_answer:
        assert property ((avs_read || avs_write) && avs_waitrequest
            |=> s_answer)
        else $error("bus answer not one cycle later");
    chk_unmapped_zero:
        assert property (s_rd_taken ##0 avs_address >= 5'h18
            |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_hi_gap_zero:
        assert property (s_rd_taken ##0 avs_address == OFF_TRANS_HIGH
            |=> avs_readdata[12:8] == 5'h00)
        else $error("high word gap not zero");
    chk_lo_fill_zero:
        assert property (s_rd_taken ##0 (avs_address == OFF_EVEN_LOW
            || avs_address == OFF_ODD_LOW) |=> avs_readdata[31:30] == 2'h0)
        else $error("page-low fill not zero");
    chk_ptr_fill:
        assert property (s_rd_taken ##0 avs_address == OFF_ENTRY_PTR
            |=> avs_readdata[30:IW] == '0)
        else $error("pointer fill not zero");
endmodule // tlbm_core_props

bind tlbm_core tlbm_core_props #(.ENTRIES(ENTRIES)) u_props (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_word(op_word),
    .op_cp_usable(op_cp_usable), .op_done(op_done),
    .op_unusable(op_unusable), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

// File: tb/tlbm_pipe.sv
/* Issuing pipeline model: presents one management word per call.
   Assumes calls come from the bench's main thread only. */
`timescale 1ns/1ns
module tlbm_pipe
    import tlbm_pkg::*;
(
    input  wire logic                        clk,
    output logic                             op_valid,
    output logic [tlbm_pkg::DATA_W-1:0]      op_word,
    output logic                             op_cp_usable,
    input  wire logic                        op_done,
    input  wire logic                        op_unusable
);
    initial begin
        op_valid = 1'b0;
        op_word = 32'h0000_0000;
        op_cp_usable = 1'b0;
    end
    task automatic issue(input logic [31:0] w, input logic u,
                         output logic d, output logic x);
        @(posedge clk);
        op_valid <= 1'b1;
        op_word <= w;
        op_cp_usable <= u;
        @(posedge clk);
        op_valid <= 1'b0;
        // Idle word inverted so a stale copy never decodes
        op_word <= ~w;
        op_cp_usable <= ~u;
        #1;
        d = op_done;
        x = op_unusable;
    endtask
endmodule // tlbm_pipe
